// file: design/sha_pkg.sv
// Constants shared by the adapter host-command interpreter and its bench.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package sha_pkg;
  // Register byte addresses.
  localparam logic [7:0] SHA_ADDR_CMD = 8'h00;
  localparam logic [7:0] SHA_ADDR_DATA_IN = 8'h04;
  localparam logic [7:0] SHA_ADDR_STATUS = 8'h08;
  localparam logic [7:0] SHA_ADDR_INT = 8'h0c;
  localparam logic [7:0] SHA_ADDR_CTRL = 8'h10;
  localparam logic [7:0] SHA_ADDR_CFG = 8'h14;
  localparam logic [7:0] SHA_ADDR_SYNC = 8'h18;
  localparam logic [7:0] SHA_ADDR_TGT = 8'h1c;
  // Status register bit positions.
  localparam int SHA_ST_DIAG_ACT = 7;
  localparam int SHA_ST_DIAG_FAIL = 6;
  localparam int SHA_ST_READY = 4;
  localparam int SHA_ST_DIN_RDY = 2;
  localparam int SHA_ST_INVALID = 0;
  localparam int SHA_ST_BUSY = 3;
  // Interrupt register bit positions.
  localparam int SHA_INT_VALID = 7;
  localparam int SHA_INT_DONE = 2;
  // Control register bit positions (write one to clear the done, valid and invalid flags).
  localparam int SHA_CTRL_IRST = 0;
  // Command opcodes.
  localparam logic [7:0] SHA_OP_INQ_CFG = 8'h0b;
  localparam logic [7:0] SHA_OP_TGT_MODE = 8'h0c;
  localparam logic [7:0] SHA_OP_INQ_SETUP = 8'h0d;
  localparam logic [7:0] SHA_OP_WR_RAM = 8'h1a;
  localparam logic [7:0] SHA_OP_RD_RAM = 8'h1b;
  localparam logic [7:0] SHA_OP_WR_FIFO = 8'h1c;
  localparam logic [7:0] SHA_OP_RD_FIFO = 8'h1d;
  localparam logic [7:0] SHA_OP_ECHO = 8'h1f;
  localparam logic [7:0] SHA_OP_DIAG = 8'h20;
  // Transfer lengths and reply sizes.
  localparam int SHA_RAM_BYTES = 64;
  localparam int SHA_FIFO_BYTES = 54;
  localparam int SHA_SETUP_BYTES = 17;
  localparam logic [7:0] SHA_MODE_INIT = 8'h00;
  localparam logic [7:0] SHA_MODE_TARGET = 8'h01;
  // Target answers for a selection.
  localparam logic [7:0] SHA_SENSE_NOT_READY = 8'h02;
  localparam logic [7:0] SHA_ASC_NOT_READY = 8'h04;
  localparam logic [1:0] SHA_ANS_GOOD = 2'h0;
  localparam logic [1:0] SHA_ANS_CHECK = 2'h1;
  localparam logic [1:0] SHA_ANS_BUSY = 2'h2;
  // Diagnostic run time.
  localparam int SHA_DIAG_NS = 2000;
  localparam int SHA_CLK_NS = 8;
  localparam int SHA_DIAG_CYC = SHA_DIAG_NS / SHA_CLK_NS;
  typedef enum logic [2:0] {
    SHA_IDLE = 3'b000,
    SHA_PARAM = 3'b001,
    SHA_EXEC = 3'b011,
    SHA_REPLY = 3'b010,
    SHA_DMA = 3'b110,
    SHA_DIAG = 3'b111
  } sha_state_t;
endpackage

// file: design/sha_ram.sv
// Byte store for the adapter local RAM and the bus-master chip FIFO image.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module sha_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// file: design/sha_cmd.sv
// Host-command interpreter: APB registers, command decode, DMA sequencing, diagnostics.
// Assumes a DMA master outside that moves one byte per accepted request.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sha_cmd #(
  parameter int DIAG_CYC = sha_pkg::SHA_DIAG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic dma_req,
  output logic dma_to_host,
  output logic [23:0] dma_addr,
  output logic [7:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  input wire logic target_support,
  input wire logic [7:0] diag_fail_count,
  input wire logic sel_req,
  input wire logic [2:0] sel_unit,
  output logic [1:0] sel_answer,
  output logic [7:0] sel_sense,
  output logic [7:0] sel_asc,
  output logic target_mode,
  output logic [7:0] unit_mask
);
  logic [7:0] op_reg, din_reg, cnt_reg, len_reg, total_reg, p0_reg, tgt_present_reg, ram_rdata;
  logic [23:0] addr_reg, mbx_base_reg;
  logic [1:0] pcnt_reg, pneed;
  logic din_rdy_reg, invalid_reg, done_reg, interrupt_valid_flag_reg, diagnostic_failure_flag_reg, diagnostic_active_flag_reg;
  logic [7:0] cfg_reg, setup0_reg, rate_reg, ton_reg, toff_reg, mbx_cnt_reg, disc_reg;
  logic [2:0] own_id_reg;
  logic [63:0] sync_reg;
  logic [15:0] diag_cnt_reg;
  logic sync1_reg, sel_reg, sel_prev_reg, echo_wait_reg, tgt_busy_reg;
  sha_pkg::sha_state_t state_reg;
  logic wr_en, rd_en, cmd_wr, din_rd, ram_we, is_fifo;
  logic [6:0] ram_waddr, ram_raddr;
  function automatic logic [1:0] param_count(input logic [7:0] op);
    unique case (op)
      sha_pkg::SHA_OP_TGT_MODE: param_count = 2'd2;
      sha_pkg::SHA_OP_INQ_SETUP, sha_pkg::SHA_OP_ECHO: param_count = 2'd1;
      sha_pkg::SHA_OP_WR_RAM, sha_pkg::SHA_OP_RD_RAM,
      sha_pkg::SHA_OP_WR_FIFO, sha_pkg::SHA_OP_RD_FIFO: param_count = 2'd3;
      default: param_count = 2'd0;
    endcase
  endfunction
  function automatic logic [7:0] setup_byte(input logic [7:0] idx);
    logic [2:0] t;
    t = idx[2:0];
    setup_byte = 8'h00;
    unique case (idx)
      8'd0: setup_byte = {6'h00, setup0_reg[1:0]};
      8'd1: setup_byte = rate_reg;
      8'd2: setup_byte = ton_reg;
      8'd3: setup_byte = toff_reg;
      8'd4: setup_byte = mbx_cnt_reg;
      8'd5: setup_byte = mbx_base_reg[23:16];
      8'd6: setup_byte = mbx_base_reg[15:8];
      8'd7: setup_byte = mbx_base_reg[7:0];
      8'd16: setup_byte = disc_reg;
      default: begin
        if (idx < 8'd16 && t != own_id_reg && tgt_present_reg[t]) begin
          setup_byte = sync_reg[t*8 +: 8];
        end
      end
    endcase
  endfunction
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cmd_wr = wr_en && paddr == sha_pkg::SHA_ADDR_CMD;
  assign din_rd = rd_en && paddr == sha_pkg::SHA_ADDR_DATA_IN;
  assign pneed = param_count(op_reg);
  assign is_fifo = op_reg == sha_pkg::SHA_OP_WR_FIFO || op_reg == sha_pkg::SHA_OP_RD_FIFO;
  assign total_reg = is_fifo ? 8'(sha_pkg::SHA_FIFO_BYTES) : 8'(sha_pkg::SHA_RAM_BYTES);
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        sha_pkg::SHA_ADDR_CMD, sha_pkg::SHA_ADDR_DATA_IN, sha_pkg::SHA_ADDR_STATUS,
        sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_ADDR_CTRL, sha_pkg::SHA_ADDR_CFG,
        sha_pkg::SHA_ADDR_SYNC, sha_pkg::SHA_ADDR_TGT: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end
  // Read data is loaded in the setup phase so that it stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        sha_pkg::SHA_ADDR_DATA_IN: prdata <= {24'h000000, din_reg};
        sha_pkg::SHA_ADDR_STATUS: prdata <= {24'h000000, diagnostic_active_flag_reg, diagnostic_failure_flag_reg, 1'b0,
          state_reg == sha_pkg::SHA_IDLE, tgt_busy_reg, din_rdy_reg, 1'b0, invalid_reg};
        sha_pkg::SHA_ADDR_INT: prdata <= {24'h000000, interrupt_valid_flag_reg, 4'h0, done_reg, 2'h0};
        sha_pkg::SHA_ADDR_CFG: prdata <= {8'h00, mbx_base_reg[7:0], cfg_reg, 5'h00, own_id_reg};
        sha_pkg::SHA_ADDR_SYNC: prdata <= {24'h000000, setup0_reg};
        sha_pkg::SHA_ADDR_TGT: prdata <= {16'h0000, tgt_present_reg, unit_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // Setup values that software loads to stand in for the adapter's firmware tables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_id_reg <= 3'h7;
      cfg_reg <= 8'h00;
      setup0_reg <= 8'h00;
      rate_reg <= 8'h00;
      ton_reg <= 8'h00;
      toff_reg <= 8'h00;
      mbx_cnt_reg <= 8'h00;
      mbx_base_reg <= 24'h000000;
      disc_reg <= 8'h00;
      tgt_present_reg <= 8'h00;
      sync_reg <= 64'h0;
    end else if (wr_en) begin
      unique case (paddr)
        sha_pkg::SHA_ADDR_CFG: begin
          own_id_reg <= pwdata[2:0];
          cfg_reg <= pwdata[15:8];
          mbx_cnt_reg <= pwdata[23:16];
        end
        sha_pkg::SHA_ADDR_SYNC: begin
          setup0_reg <= {6'h00, pwdata[1:0]};
          rate_reg <= pwdata[15:8];
          ton_reg <= pwdata[23:16];
          toff_reg <= pwdata[31:24];
        end
        sha_pkg::SHA_ADDR_TGT: begin
          tgt_present_reg <= pwdata[7:0];
          disc_reg <= pwdata[15:8];
          sync_reg[pwdata[18:16]*8 +: 8] <= pwdata[31:24];
          mbx_base_reg <= {pwdata[31:24], mbx_base_reg[23:8]} ;
        end
        default: ;
      endcase
    end
  end
  // Command sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= sha_pkg::SHA_IDLE;
      op_reg <= 8'h00;
      p0_reg <= 8'h00;
      pcnt_reg <= 2'd0;
      addr_reg <= 24'h000000;
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
      din_reg <= 8'h00;
      din_rdy_reg <= 1'b0;
      invalid_reg <= 1'b0;
      done_reg <= 1'b0;
      interrupt_valid_flag_reg <= 1'b0;
      diagnostic_failure_flag_reg <= 1'b0;
      diagnostic_active_flag_reg <= 1'b0;
      echo_wait_reg <= 1'b0;
      target_mode <= 1'b0;
      unit_mask <= 8'h00;
      diag_cnt_reg <= 16'h0000;
    end else begin
      if (wr_en && paddr == sha_pkg::SHA_ADDR_CTRL && pwdata[sha_pkg::SHA_CTRL_IRST]) begin
        done_reg <= 1'b0;
        interrupt_valid_flag_reg <= 1'b0;
        invalid_reg <= 1'b0;
      end
      if (din_rd) begin
        din_rdy_reg <= 1'b0;
      end
      unique case (state_reg)
        sha_pkg::SHA_IDLE: begin
          if (cmd_wr) begin
            op_reg <= pwdata[7:0];
            pcnt_reg <= 2'd0;
            state_reg <= param_count(pwdata[7:0]) == 2'd0 ? sha_pkg::SHA_EXEC
                                                         : sha_pkg::SHA_PARAM;
          end
        end
        sha_pkg::SHA_PARAM: begin
          if (cmd_wr) begin
            pcnt_reg <= pcnt_reg + 2'd1;
            if (pcnt_reg == 2'd0) begin
              p0_reg <= pwdata[7:0];
            end
            addr_reg <= {addr_reg[15:0], pwdata[7:0]};
            len_reg <= pwdata[7:0];
            if (pcnt_reg + 2'd1 == pneed) begin
              state_reg <= sha_pkg::SHA_EXEC;
            end
          end
        end
        sha_pkg::SHA_EXEC: begin
          cnt_reg <= 8'h00;
          state_reg <= sha_pkg::SHA_IDLE;
          unique case (op_reg)
            sha_pkg::SHA_OP_TGT_MODE: begin
              if (!target_support || (p0_reg == sha_pkg::SHA_MODE_INIT && tgt_busy_reg)
                  || (p0_reg != sha_pkg::SHA_MODE_INIT && p0_reg != sha_pkg::SHA_MODE_TARGET)
                  || (p0_reg == sha_pkg::SHA_MODE_TARGET && len_reg == 8'h00)) begin
                invalid_reg <= 1'b1;
              end else begin
                target_mode <= p0_reg == sha_pkg::SHA_MODE_TARGET;
                if (p0_reg == sha_pkg::SHA_MODE_TARGET) begin
                  unit_mask <= len_reg;
                end
              end
              done_reg <= 1'b1;
            end
            sha_pkg::SHA_OP_INQ_CFG: begin
              len_reg <= 8'd3;
              state_reg <= sha_pkg::SHA_REPLY;
            end
            sha_pkg::SHA_OP_INQ_SETUP, sha_pkg::SHA_OP_ECHO: begin
              state_reg <= sha_pkg::SHA_REPLY;
            end
            sha_pkg::SHA_OP_WR_RAM, sha_pkg::SHA_OP_RD_RAM,
            sha_pkg::SHA_OP_WR_FIFO, sha_pkg::SHA_OP_RD_FIFO: begin
              state_reg <= sha_pkg::SHA_DMA;
            end
            sha_pkg::SHA_OP_DIAG: begin
              diagnostic_active_flag_reg <= 1'b1;
              diagnostic_failure_flag_reg <= 1'b0;
              din_rdy_reg <= 1'b0;
              target_mode <= 1'b0;
              unit_mask <= 8'h00;
              diag_cnt_reg <= 16'(DIAG_CYC);
              state_reg <= sha_pkg::SHA_DIAG;
            end
            default: begin
              invalid_reg <= 1'b1;
              done_reg <= 1'b1;
            end
          endcase
        end
        sha_pkg::SHA_REPLY: begin
          if (op_reg == sha_pkg::SHA_OP_ECHO) begin
            if (!echo_wait_reg) begin
              din_reg <= len_reg;
              din_rdy_reg <= 1'b1;
              echo_wait_reg <= 1'b1;
            end else if (din_rd) begin
              echo_wait_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= sha_pkg::SHA_IDLE;
            end
          end else if (cnt_reg == len_reg) begin
            done_reg <= 1'b1;
            state_reg <= sha_pkg::SHA_IDLE;
          end else if (!din_rdy_reg || din_rd) begin
            din_reg <= op_reg == sha_pkg::SHA_OP_INQ_CFG
              ? (cnt_reg == 8'd2 ? {5'h00, own_id_reg} : cfg_reg)
              : setup_byte(cnt_reg);
            din_rdy_reg <= 1'b1;
            cnt_reg <= cnt_reg + 8'd1;
          end
        end
        sha_pkg::SHA_DMA: begin
          if (dma_ack) begin
            cnt_reg <= cnt_reg + 8'd1;
            if (cnt_reg + 8'd1 == total_reg) begin
              done_reg <= 1'b1;
              state_reg <= sha_pkg::SHA_IDLE;
            end
          end
        end
        sha_pkg::SHA_DIAG: begin
          if (diag_cnt_reg != 16'h0000) begin
            diag_cnt_reg <= diag_cnt_reg - 16'h0001;
          end else begin
            diagnostic_active_flag_reg <= 1'b0;
            if (diag_fail_count != 8'h00) begin
              diagnostic_failure_flag_reg <= 1'b1;
              din_reg <= diag_fail_count;
              din_rdy_reg <= 1'b1;
            end
            done_reg <= 1'b1;
            interrupt_valid_flag_reg <= 1'b1;
            state_reg <= sha_pkg::SHA_IDLE;
          end
        end
        default: state_reg <= sha_pkg::SHA_IDLE;
      endcase
    end
  end
  // DMA byte stream; local RAM at 0-63, FIFO image from 64.
  assign dma_req = state_reg == sha_pkg::SHA_DMA;
  assign dma_to_host = op_reg == sha_pkg::SHA_OP_RD_RAM || op_reg == sha_pkg::SHA_OP_RD_FIFO;
  assign dma_addr = addr_reg + {16'h0000, cnt_reg};
  assign dma_wdata = ram_rdata;
  assign ram_we = dma_req && dma_ack && !dma_to_host;
  assign ram_waddr = {is_fifo, cnt_reg[5:0]};
  assign ram_raddr = {is_fifo, (dma_req && dma_ack) ? cnt_reg[5:0] + 6'd1 : cnt_reg[5:0]};
  sha_ram #(.DEPTH(128), .AW(7)) u_ram (
    .pclk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(dma_rdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );
  // Selection handling: the request arrives from the SCSI side and is synchronised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sel_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
      tgt_busy_reg <= 1'b0;
      sel_answer <= sha_pkg::SHA_ANS_GOOD;
      sel_sense <= 8'h00;
      sel_asc <= 8'h00;
    end else begin
      sync1_reg <= sel_req;
      sel_reg <= sync1_reg;
      sel_prev_reg <= sel_reg;
      if (sel_reg && !sel_prev_reg) begin
        sel_sense <= 8'h00;
        sel_asc <= 8'h00;
        if (!target_mode || !unit_mask[sel_unit]) begin
          sel_answer <= sha_pkg::SHA_ANS_CHECK;
          sel_sense <= sha_pkg::SHA_SENSE_NOT_READY;
          sel_asc <= sha_pkg::SHA_ASC_NOT_READY;
        end else if (tgt_busy_reg || state_reg != sha_pkg::SHA_IDLE) begin
          sel_answer <= sha_pkg::SHA_ANS_BUSY;
        end else begin
          sel_answer <= sha_pkg::SHA_ANS_GOOD;
          tgt_busy_reg <= 1'b1;
        end
      end else if (!sel_reg && sel_prev_reg) begin
        tgt_busy_reg <= tgt_busy_reg && target_mode && sel_answer != sha_pkg::SHA_ANS_GOOD;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/sha_cmd_props.sv
// Port checker for the host-command interpreter.
// Bound to sha_cmd from the testbench top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sha_cmd_props #(
  parameter int DIAG_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma_req,
  input wire logic dma_to_host,
  input wire logic [23:0] dma_addr,
  input wire logic dma_ack,
  input wire logic sel_req,
  input wire logic [2:0] sel_unit,
  input wire logic [1:0] sel_answer,
  input wire logic [7:0] sel_sense,
  input wire logic [7:0] sel_asc,
  input wire logic target_mode,
  input wire logic [7:0] unit_mask
);
  logic [7:0] acks_reg;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counts bytes moved in the current burst so its length can be judged at the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acks_reg <= 8'h00;
    end else if (!dma_req) begin
      acks_reg <= 8'h00;
    end else if (dma_ack) begin
      acks_reg <= acks_reg + 8'h01;
    end
  end
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (psel && penable && paddr > 8'h1c |-> pslverr)
    else $error("unmapped access without error");
  AST_SEL_CHECK: assert property (sel_req && (!target_mode || !unit_mask[sel_unit])
    |-> ##[1:3] (sel_answer == sha_pkg::SHA_ANS_CHECK && sel_sense == 8'h02
    && sel_asc == 8'h04))
    else $error("selection not answered with check condition");
  AST_SEL_ON: assert property (sel_req && target_mode && unit_mask[sel_unit]
    |-> ##[1:3] sel_answer != sha_pkg::SHA_ANS_CHECK)
    else $error("enabled unit answered check condition");
  AST_MASK: assert property (target_mode |-> unit_mask != 8'h00)
    else $error("target mode with empty unit mask");
  AST_DMA_STEP: assert property (dma_req && dma_ack ##1 dma_req
    |-> dma_addr == $past(dma_addr) + 24'h000001)
    else $error("dma address did not advance by one");
  AST_DMA_DIR: assert property (dma_req && $past(dma_req) |-> $stable(dma_to_host))
    else $error("dma direction changed in a burst");
  AST_DMA_LEN: assert property ($fell(dma_req) |-> acks_reg == 8'h40 || acks_reg == 8'h36)
    else $error("dma burst length wrong");
  cover property ($fell(dma_req) && dma_to_host);
  cover property (sel_req && sel_answer == sha_pkg::SHA_ANS_CHECK);
  cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// file: bench/sha_host_mem_model.sv
// Host-memory side of the adapter DMA port.
// Acks one byte at a time, with a one-cycle gap between bytes, or a three-cycle gap when slow.
`timescale 1ns/1ps
`default_nettype none
module sha_host_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic dma_req,
  input wire logic dma_to_host,
  input wire logic [23:0] dma_addr,
  input wire logic [7:0] dma_wdata,
  output logic dma_ack,
  output logic [7:0] dma_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] gap_reg;
  int moved;
  // Outside an ack the bus shows the inverse pattern, so stale data never matches.
  assign dma_rdata = dma_ack ? (dma_addr[7:0] ^ 8'h5a) : ~(dma_addr[7:0] ^ 8'h5a);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 1'b0;
      gap_reg <= 2'h0;
    end else if (dma_ack) begin
      dma_ack <= 1'b0;
      gap_reg <= slow ? 2'h2 : 2'h0;
    end else if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end else begin
      dma_ack <= dma_req;
    end
  end
  always_ff @(posedge pclk) begin
    if (dma_ack && dma_req) begin
      moved <= moved + 1;
      if (dma_to_host) begin
        mem[dma_addr[7:0]] <= dma_wdata;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/scsi_adapter_host_command_set_tb.sv
// Self-checking bench for the host-command interpreter.
// Drives APB and selection pins; a host-memory model answers DMA.
`timescale 1ns/1ps
`default_nettype none
module scsi_adapter_host_command_set_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, slow;
  logic dma_req, dma_to_host, dma_ack, target_support, sel_req, target_mode;
  logic [7:0] paddr, dma_wdata, dma_rdata, diag_fail_count, sel_sense, sel_asc, unit_mask;
  logic [31:0] pwdata, prdata, rd_q;
  logic [23:0] dma_addr;
  logic [2:0] sel_unit;
  logic [1:0] sel_answer;
  logic [7:0] got [0:16];
  logic [7:0] ops [0:3] = '{8'h1a, 8'h1c, 8'h1b, 8'h1d};
  int fails, checks_done, base;
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  sha_cmd #(.DIAG_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_req(dma_req), .dma_to_host(dma_to_host),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .target_support(target_support), .diag_fail_count(diag_fail_count),
    .sel_req(sel_req), .sel_unit(sel_unit), .sel_answer(sel_answer),
    .sel_sense(sel_sense), .sel_asc(sel_asc), .target_mode(target_mode),
    .unit_mask(unit_mask));
  sha_host_mem_model u_host (.pclk(pclk), .presetn(presetn), .slow(slow),
    .dma_req(dma_req), .dma_to_host(dma_to_host), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err_q = pslverr;
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle keeps back-to-back calls from driving psel twice in one step.
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] b);
    bus(1'b1, sha_pkg::SHA_ADDR_CMD, {24'h0, b});
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while (rd_q[b] !== v && n < 300) begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    chk({31'h0, rd_q[b]}, {31'h0, v});
  endtask
  task automatic clr;
    bus(1'b1, sha_pkg::SHA_ADDR_CTRL, 32'h1);
  endtask
  task automatic pull(input int i);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_DIN_RDY, 1'b1);
    bus(1'b0, sha_pkg::SHA_ADDR_DATA_IN, 32'h0);
    got[i] = rd_q[7:0];
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite, slow, target_support, sel_req} = 7'h0;
    {paddr, diag_fail_count, pwdata, sel_unit} = 51'h0;
    fails = 0;
    checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_READY, 1'b1);
    chk({31'h0, target_mode}, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    cmd(sha_pkg::SHA_OP_ECHO);
    cmd(8'ha5);
    pull(0);
    chk({24'h0, got[0]}, 32'ha5);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_DIN_RDY, 1'b0);
    wait_bit(sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_INT_DONE, 1'b1);
    clr;
    $display("echo done");
    bus(1'b1, sha_pkg::SHA_ADDR_CFG, 32'h0000ab05);
    cmd(sha_pkg::SHA_OP_INQ_CFG);
    for (int i = 0; i < 3; i++) pull(i);
    chk({24'h0, got[2]}, 32'h05);
    clr;
    bus(1'b1, sha_pkg::SHA_ADDR_SYNC, 32'h33221103);
    bus(1'b1, sha_pkg::SHA_ADDR_TGT, 32'h9f0500ff);
    bus(1'b1, sha_pkg::SHA_ADDR_TGT, 32'h8a0200ff);
    bus(1'b1, sha_pkg::SHA_ADDR_TGT, 32'h9f01a5fb);
    cmd(sha_pkg::SHA_OP_INQ_SETUP);
    cmd(8'h11);
    for (int i = 0; i < 17; i++) pull(i);
    chk({24'h0, got[0]}, 32'h03);
    chk({got[1], got[2], got[3]}, 32'h112233);
    chk({24'h0, got[4]}, 32'h00);
    chk({got[9], got[10], got[13]}, 32'h9f0000);
    chk({24'h0, got[16]}, 32'ha5);
    clr;
    cmd(sha_pkg::SHA_OP_INQ_SETUP);
    cmd(8'h02);
    for (int i = 0; i < 2; i++) pull(i);
    wait_bit(sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_INT_DONE, 1'b1);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_DIN_RDY, 1'b0);
    clr;
    $display("inquiry done");
    cmd(sha_pkg::SHA_OP_TGT_MODE);
    cmd(8'h01);
    cmd(8'h01);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_INVALID, 1'b1);
    clr;
    target_support <= 1'b1;
    cmd(sha_pkg::SHA_OP_TGT_MODE);
    cmd(8'h02);
    cmd(8'h01);
    wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_INVALID, 1'b1);
    clr;
    cmd(sha_pkg::SHA_OP_TGT_MODE);
    cmd(8'h01);
    cmd(8'h04);
    wait_bit(sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_INT_DONE, 1'b1);
    chk({23'h0, target_mode, unit_mask}, 32'h104);
    clr;
    for (int u = 0; u < 8; u++) begin
      sel_unit <= u[2:0];
      sel_req <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({30'h0, sel_answer == sha_pkg::SHA_ANS_CHECK}, {30'h0, u != 2});
      sel_req <= 1'b0;
      @(posedge pclk);
    end
    $display("target mode done");
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      base = u_host.moved;
      cmd(ops[k]);
      cmd(8'h00);
      cmd(8'h00);
      cmd(8'h10);
      if (k == 0) begin
        sel_unit <= 3'd2;
        sel_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({30'h0, sel_answer}, {30'h0, sha_pkg::SHA_ANS_BUSY});
        sel_req <= 1'b0;
        @(posedge pclk);
      end
      wait_bit(sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_INT_DONE, 1'b1);
      chk(u_host.moved - base, k[0] ? 32'd54 : 32'd64);
      clr;
    end
    for (int i = 16; i < 80; i++) chk({24'h0, u_host.mem[i]}, {24'h0, i[7:0] ^ 8'h5a});
    $display("dma done");
    for (int f = 0; f < 2; f++) begin
      diag_fail_count <= f ? 8'h03 : 8'h00;
      cmd(sha_pkg::SHA_OP_DIAG);
      wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_DIAG_ACT, 1'b1);
      wait_bit(sha_pkg::SHA_ADDR_STATUS, sha_pkg::SHA_ST_DIAG_ACT, 1'b0);
      wait_bit(sha_pkg::SHA_ADDR_INT, sha_pkg::SHA_INT_DONE, 1'b1);
      chk({31'h0, rd_q[sha_pkg::SHA_INT_VALID]}, 32'h1);
      chk({31'h0, target_mode}, 32'h0);
      bus(1'b0, sha_pkg::SHA_ADDR_STATUS, 32'h0);
      chk({30'h0, rd_q[sha_pkg::SHA_ST_DIAG_FAIL], rd_q[2]}, f ? 32'h3 : 32'h0);
      if (f) begin
        bus(1'b0, sha_pkg::SHA_ADDR_DATA_IN, 32'h0);
        chk({24'h0, rd_q[7:0]}, 32'h03);
      end
      clr;
    end
    $display("diagnostic done");
    report_and_stop;
  end
endmodule
bind sha_cmd sha_cmd_props #(.DIAG_CYC(DIAG_CYC)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .dma_req(dma_req), .dma_to_host(dma_to_host), .dma_addr(dma_addr), .dma_ack(dma_ack),
  .sel_req(sel_req), .sel_unit(sel_unit), .sel_answer(sel_answer), .sel_sense(sel_sense),
  .sel_asc(sel_asc), .target_mode(target_mode), .unit_mask(unit_mask));
`default_nettype wire
